/* File: hdl/spl_params.svh */
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH
// Stage count of shift and storage registers
`define SPL_WIDTH 8
// Cleared value of the shift, storage and output registers
`define SPL_CLEAR_VAL 8'h00
`endif

/* File: hdl/spl_pkg.sv */
package spl_pkg;
  // Edge kind seen on a synchronised strobe
  typedef enum logic [1:0] {
    SPL_EDGE_NONE = 2'b00,
    SPL_EDGE_RISE = 2'b01,
    SPL_EDGE_FALL = 2'b10
  } spl_edge_t;
endpackage : spl_pkg

/* File: hdl/spl_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser with edge detect
// ----------------------------------------
module spl_sync (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic level_o,
  output spl_pkg::spl_edge_t edge_o
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // Next values; first stage is read only by the second
  always_comb
  begin
    next_meta = pin_i;
    next_sync = meta;
    next_prev = sync;
  end

  // Registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // Edge decode from settled stages only
  always_comb
  begin
    level_o = sync;
    if (sync && !prev)
      edge_o = spl_pkg::SPL_EDGE_RISE;
    else if (!sync && prev)
      edge_o = spl_pkg::SPL_EDGE_FALL;
    else
      edge_o = spl_pkg::SPL_EDGE_NONE;
  end
endmodule : spl_sync

/* File: hdl/spl_latch.sv */
`timescale 1ns/1ps
`include "spl_params.svh"
module spl_latch #(
  parameter int WIDTH = `SPL_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic serial_shift_strobe_i,
  input wire logic latch_transfer_strobe_i,
  input wire logic chain_input_i,
  input wire logic wipe_all_n_i,
  input wire logic drive_disable_n_i,
  output logic chain_output_o,
  output logic [WIDTH-1:0] sink_on_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  spl_pkg::spl_edge_t shift_edge;
  spl_pkg::spl_edge_t latch_edge;
  logic data_lvl;
  logic wipe_n_lvl;
  logic dis_lvl;

  // Strobes act on edges only; their levels stay unused
  spl_sync u_shift (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(serial_shift_strobe_i),
    .level_o(),
    .edge_o(shift_edge)
  );
  spl_sync u_latch (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(latch_transfer_strobe_i),
    .level_o(),
    .edge_o(latch_edge)
  );
  // Data delayed like the strobe so its setup is kept
  spl_sync u_data (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(chain_input_i),
    .level_o(data_lvl),
    .edge_o()
  );
  // Reads as wiped until the stages fill; harmless, all is clear then
  spl_sync u_wipe (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(wipe_all_n_i),
    .level_o(wipe_n_lvl),
    .edge_o()
  );
  spl_sync u_dis (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(drive_disable_n_i),
    .level_o(dis_lvl),
    .edge_o()
  );

  // ----------------------------------------
  // Shift, storage and chain registers
  // ----------------------------------------
  logic [WIDTH-1:0] shift_q;
  logic [WIDTH-1:0] store_q;
  logic chain_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] next_shift_q;
  logic [WIDTH-1:0] next_store_q;
  logic next_chain_q;
  logic [WIDTH-1:0] next_out_q;

  // Next values; wipe dominates all strobes
  always_comb
  begin
    next_shift_q = shift_q;
    next_store_q = store_q;
    next_chain_q = chain_q;
    if (!wipe_n_lvl)
    begin
      next_shift_q = `SPL_CLEAR_VAL;
      next_store_q = `SPL_CLEAR_VAL;
      next_chain_q = 1'b0;
    end
    else
    begin
      if (shift_edge == spl_pkg::SPL_EDGE_RISE)
        next_shift_q = {shift_q[WIDTH-2:0], data_lvl};
      if (shift_edge == spl_pkg::SPL_EDGE_FALL)
        next_chain_q = shift_q[WIDTH-1];
      // Strobes arriving together: storage takes pre-shift contents
      if (latch_edge == spl_pkg::SPL_EDGE_RISE)
        next_store_q = shift_q;
    end
  end

  // Output buffer gating; updated in the same cycle as storage, registered output
  always_comb
  begin
    if (dis_lvl || !wipe_n_lvl)
      next_out_q = `SPL_CLEAR_VAL;
    else
      next_out_q = next_store_q;
  end

  // Registers only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      shift_q <= `SPL_CLEAR_VAL;
      store_q <= `SPL_CLEAR_VAL;
      chain_q <= 1'b0;
      out_q <= `SPL_CLEAR_VAL;
    end
    else
    begin
      shift_q <= next_shift_q;
      store_q <= next_store_q;
      chain_q <= next_chain_q;
      out_q <= next_out_q;
    end
  end

  assign chain_output_o = chain_q;
  assign sink_on_o = out_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_shift_in;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wipe_n_lvl && shift_edge == spl_pkg::SPL_EDGE_RISE)
      |=> shift_q == {$past(shift_q[WIDTH-2:0]), $past(data_lvl)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift wrong");

  property p_shift_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wipe_n_lvl && shift_edge != spl_pkg::SPL_EDGE_RISE) |=> $stable(shift_q);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift moved");

  property p_latch;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wipe_n_lvl && latch_edge == spl_pkg::SPL_EDGE_RISE)
      |=> store_q == $past(shift_q);
  endproperty
  a_latch: assert property (p_latch) else $error("latch wrong");

  property p_wipe;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !wipe_n_lvl |=> (shift_q == '0 && store_q == '0 && !chain_q);
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe failed");

  property p_wipe_out;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !wipe_n_lvl |=> sink_on_o == '0;
  endproperty
  a_wipe_out: assert property (p_wipe_out) else $error("outputs on in wipe");

  property p_disable;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    dis_lvl |=> sink_on_o == '0;
  endproperty
  a_disable: assert property (p_disable) else $error("outputs on disabled");

  property p_follow;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (!dis_lvl && wipe_n_lvl) |=> sink_on_o == store_q;
  endproperty
  a_follow: assert property (p_follow) else $error("outputs not following");

  property p_chain;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wipe_n_lvl && shift_edge == spl_pkg::SPL_EDGE_FALL)
      |=> chain_output_o == $past(shift_q[WIDTH-1]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain wrong");

  property p_chain_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wipe_n_lvl && shift_edge != spl_pkg::SPL_EDGE_FALL) |=> $stable(chain_output_o);
  endproperty
  a_chain_hold: assert property (p_chain_hold) else $error("chain moved");

  property p_store_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wipe_n_lvl && latch_edge != spl_pkg::SPL_EDGE_RISE) |=> $stable(store_q);
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("storage moved");

  // A sinking bit must be a one held in storage
  property p_sink_source;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (sink_on_o & ~store_q) == '0;
  endproperty
  a_sink_source: assert property (p_sink_source) else $error("sink without data");

  // Enabled outputs show freshly latched shift contents one cycle later
  property p_latch_out;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (!dis_lvl && wipe_n_lvl && latch_edge == spl_pkg::SPL_EDGE_RISE)
      |=> sink_on_o == $past(shift_q);
  endproperty
  a_latch_out: assert property (p_latch_out) else $error("latch not at outputs");

  // ----------------------------------------
  // Coverage of main scenarios
  // ----------------------------------------
  c_shift: cover property (@(posedge clk_sys_i) shift_edge == spl_pkg::SPL_EDGE_RISE);
  c_disable: cover property (@(posedge clk_sys_i) dis_lvl && store_q != '0);
  c_latch: cover property (@(posedge clk_sys_i) latch_edge == spl_pkg::SPL_EDGE_RISE);
  c_on: cover property (@(posedge clk_sys_i) sink_on_o == 8'hff);
  c_wipe: cover property (@(posedge clk_sys_i) !wipe_n_lvl && store_q == '0);
endmodule : spl_latch

/* File: sim/spl_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host driving the serial chain pins
// ----------------------------------------
module spl_host (
  input wire logic clk_i,
  output logic shift_o,
  output logic latch_o,
  output logic data_o
);
  // Pins idle low from time zero
  initial
  begin
    shift_o = 1'b0;
    latch_o = 1'b0;
    data_o = 1'b0;
  end
  // Every pin change lands just after an edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // Data held around the rise, then scrambled so stale bits cannot pass
  task automatic shift_rise(input logic b);
    data_o = b;
    step(4);
    shift_o = 1'b1;
    step(4);
    data_o = ~b;
  endtask : shift_rise
  task automatic shift_fall();
    shift_o = 1'b0;
    step(4);
  endtask : shift_fall
  task automatic latch_pulse();
    latch_o = 1'b1;
    step(4);
    latch_o = 1'b0;
    step(4);
  endtask : latch_pulse
  // Eight bits first-in-most-significant, then one latch pulse
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      shift_rise(v[i]);
      shift_fall();
    end
    latch_pulse();
  endtask : send_byte
endmodule : spl_host

/* File: sim/spl_latch_tb.sv */
`timescale 1ns/1ps
module spl_latch_tb;
  logic clk_sys_i;
  logic sys_rst_i;
  logic wipe_all_n_i;
  logic drive_disable_n_i;
  logic shift_s;
  logic latch_s;
  logic data_s;
  logic chain_output_o;
  logic [7:0] sink_on_o;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  spl_latch #(.WIDTH(8)) u_spl_latch (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .serial_shift_strobe_i(shift_s),
    .latch_transfer_strobe_i(latch_s),
    .chain_input_i(data_s),
    .wipe_all_n_i(wipe_all_n_i),
    .drive_disable_n_i(drive_disable_n_i),
    .chain_output_o(chain_output_o),
    .sink_on_o(sink_on_o)
  );
  spl_host u_spl_host (.clk_i(clk_sys_i), .shift_o(shift_s), .latch_o(latch_s), .data_o(data_s));
  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_n
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Two words back to back; chain shows the first bit sent
  task automatic t_shift_latch();
    u_spl_host.send_byte(8'ha5);
    wait_n(6);
    chk(8'ha5, sink_on_o);
    chk(8'h01, {7'h00, chain_output_o});
    u_spl_host.send_byte(8'h3c);
    wait_n(6);
    chk(8'h3c, sink_on_o);
    chk(8'h00, {7'h00, chain_output_o});
  endtask : t_shift_latch
  // Chain output moves only after the falling strobe
  task automatic t_fall_edge();
    u_spl_host.shift_rise(1'b1);
    u_spl_host.shift_fall();
    u_spl_host.shift_rise(1'b1);
    chk(8'h00, {7'h00, chain_output_o});
    u_spl_host.shift_fall();
    wait_n(2);
    chk(8'h01, {7'h00, chain_output_o});
    chk(8'h3c, sink_on_o);
    u_spl_host.latch_pulse();
    wait_n(6);
    chk(8'hf3, sink_on_o);
  endtask : t_fall_edge
  // Disable forces outputs off, release restores storage
  task automatic t_disable();
    drive_disable_n_i = 1'b1;
    wait_n(6);
    chk(8'h00, sink_on_o);
    drive_disable_n_i = 1'b0;
    wait_n(6);
    chk(8'hf3, sink_on_o);
  endtask : t_disable
  // Wipe clears everything and a shift strobe meanwhile is ignored
  task automatic t_wipe();
    wipe_all_n_i = 1'b0;
    wait_n(6);
    chk(8'h00, sink_on_o);
    chk(8'h00, {7'h00, chain_output_o});
    u_spl_host.shift_rise(1'b1);
    u_spl_host.shift_fall();
    wipe_all_n_i = 1'b1;
    wait_n(4);
    chk(8'h00, sink_on_o);
    u_spl_host.latch_pulse();
    wait_n(6);
    chk(8'h00, sink_on_o);
    chk(8'h00, {7'h00, chain_output_o});
  endtask : t_wipe
  initial
  begin
    sys_rst_i = 1'b1;
    wipe_all_n_i = 1'b1;
    drive_disable_n_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 1'b0;
    wait_n(3);
    t_shift_latch();
    t_fall_edge();
    t_disable();
    t_wipe();
    end_of_test();
  end
endmodule : spl_latch_tb
